// >>> src/qbio_defs.vh
`ifndef QBIO_DEFS_VH
`define QBIO_DEFS_VH
`define QBIO_WIDTH 8
`define QBIO_FADDR_W 5
`define QBIO_THIRD_PORT_FILE_REG 5'h07
`define QBIO_LATCH_RESET 8'hff
`define QBIO_RD_RESET 8'h00
`define QBIO_OP_W 3
`define QBIO_OP_NONE 3'h0
`define QBIO_OP_WRITE 3'h1
`define QBIO_OP_READ 3'h2
`define QBIO_OP_BIT_SET 3'h3
`define QBIO_OP_BIT_CLEAR 3'h4
`define QBIO_OP_RMW 3'h5
`endif

// >>> src/qbio_bit.v
`timescale 1ns/1ps
// ****************************************
// one quasi-bidirectional pin cell
// ****************************************
module qbio_bit (
   clk_sys,
   sys_rst,
   latch_load,
   latch_d,
   pin_in,
   latch_q,
   pin_sync,
   pin_out,
   pin_oe
);
   input wire clk_sys;
   input wire sys_rst;
   input wire latch_load;
   input wire latch_d;
   input wire pin_in;
   output wire latch_q;
   output wire pin_sync;
   output wire pin_out;
   output wire pin_oe;

   parameter [0:0] LATCH_INIT = 1'b1;

   reg latch_reg;
   reg meta_reg;
   reg sync_reg;

   // latch holds until the next load
   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         latch_reg <= LATCH_INIT;
      end else if (latch_load) begin
         latch_reg <= latch_d;
      end
   end

   // pin is asynchronous to the core clock
   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         meta_reg <= 1'b1;
         sync_reg <= 1'b1;
      end else begin
         meta_reg <= pin_in;
         sync_reg <= meta_reg;
      end
   end

   // strong drive only for a low; a high is left to the pull-up
   assign pin_out = 1'b0;
   assign pin_oe = ~latch_reg;
   assign latch_q = latch_reg;
   assign pin_sync = sync_reg;
endmodule

// >>> src/qbio_port.v
`timescale 1ns/1ps
`include "qbio_defs.vh"
module qbio_port (
   clk_sys,
   sys_rst,
   master_clear_n,
   file_op,
   file_addr,
   bit_sel,
   wr_data,
   op_valid,
   op_ready,
   rd_data,
   rd_valid,
   latch_state,
   pin_in,
   pin_out,
   pin_oe
);
   input wire clk_sys;
   input wire sys_rst;
   input wire master_clear_n;
   input wire [`QBIO_OP_W-1:0] file_op;
   input wire [`QBIO_FADDR_W-1:0] file_addr;
   input wire [2:0] bit_sel;
   input wire [`QBIO_WIDTH-1:0] wr_data;
   input wire op_valid;
   output wire op_ready;
   output wire [`QBIO_WIDTH-1:0] rd_data;
   output wire rd_valid;
   output wire [`QBIO_WIDTH-1:0] latch_state;
   input wire [`QBIO_WIDTH-1:0] pin_in;
   output wire [`QBIO_WIDTH-1:0] pin_out;
   output wire [`QBIO_WIDTH-1:0] pin_oe;

   // ****************************************
   // master clear synchroniser
   // ****************************************
   reg clr_meta_reg;
   reg clr_sync_reg;
   wire port_rst;

   // the port starts held and is let go only once the pin is seen high
   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         clr_meta_reg <= 1'b0;
         clr_sync_reg <= 1'b0;
      end else begin
         clr_meta_reg <= master_clear_n;
         clr_sync_reg <= clr_meta_reg;
      end
   end

   // reset deasserts synchronously; stays asserted while the pin is low
   assign port_rst = sys_rst | ~clr_sync_reg;

   // ****************************************
   // address match
   // ****************************************
   wire hit;
   wire take_op;

   assign hit = op_valid & (file_addr == `QBIO_THIRD_PORT_FILE_REG);
   // one operation per clock, stalled only while the port is held in reset
   assign op_ready = ~port_rst;
   assign take_op = hit & op_ready;

   // ****************************************
   // operation decode
   // ****************************************
   reg do_write;
   reg do_bit_set;
   reg do_bit_clear;
   reg do_rmw;
   wire load;

   always @* begin
      do_write = 1'b0;
      do_bit_set = 1'b0;
      do_bit_clear = 1'b0;
      do_rmw = 1'b0;
      case (file_op)
         `QBIO_OP_WRITE: begin
            do_write = take_op;
         end
         `QBIO_OP_BIT_SET: begin
            do_bit_set = take_op;
         end
         `QBIO_OP_BIT_CLEAR: begin
            do_bit_clear = take_op;
         end
         `QBIO_OP_RMW: begin
            do_rmw = take_op;
         end
         // a read or an empty op only answers
         `QBIO_OP_NONE, `QBIO_OP_READ: begin
            do_write = 1'b0;
         end
         default: begin
            do_write = 1'b0;
         end
      endcase
   end

   assign load = do_write | do_bit_set | do_bit_clear | do_rmw;

   // ****************************************
   // bit select decode
   // ****************************************
   reg [`QBIO_WIDTH-1:0] bit_mask;

   always @* begin
      case (bit_sel)
         3'h0: begin
            bit_mask = 8'h01;
         end
         3'h1: begin
            bit_mask = 8'h02;
         end
         3'h2: begin
            bit_mask = 8'h04;
         end
         3'h3: begin
            bit_mask = 8'h08;
         end
         3'h4: begin
            bit_mask = 8'h10;
         end
         3'h5: begin
            bit_mask = 8'h20;
         end
         3'h6: begin
            bit_mask = 8'h40;
         end
         3'h7: begin
            bit_mask = 8'h80;
         end
         default: begin
            bit_mask = 8'h00;
         end
      endcase
   end

   // ****************************************
   // write-back value
   // ****************************************
   wire [`QBIO_WIDTH-1:0] pin_sync;
   wire [`QBIO_WIDTH-1:0] set_val;
   wire [`QBIO_WIDTH-1:0] clear_val;
   reg [`QBIO_WIDTH-1:0] new_val;

   // both bit ops start from the pins, so an input held low is relatched low
   assign set_val = pin_sync | bit_mask;
   assign clear_val = pin_sync & ~bit_mask;

   // bit ops and rmw take the sampled pins, not the latch contents; a write takes wr_data
   always @* begin
      new_val = pin_sync;
      if (do_write) begin
         new_val = wr_data;
      end else if (do_bit_set) begin
         new_val = set_val;
      end else if (do_bit_clear) begin
         new_val = clear_val;
      end else if (do_rmw) begin
         new_val = pin_sync;
      end
   end

   // ****************************************
   // read path
   // ****************************************
   reg [`QBIO_WIDTH-1:0] rd_data_reg;
   reg [`QBIO_WIDTH-1:0] rd_data_next;
   reg rd_valid_reg;
   reg rd_valid_next;

   // inputs are captured on each accepted op: the read shows the pins as sampled then, held until the next op
   always @* begin
      rd_valid_next = take_op;
      rd_data_next = rd_data_reg;
      if (take_op) begin
         rd_data_next = pin_sync;
      end
   end

   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         rd_data_reg <= `QBIO_RD_RESET;
         rd_valid_reg <= 1'b0;
      end else begin
         rd_data_reg <= rd_data_next;
         rd_valid_reg <= rd_valid_next;
      end
   end

   assign rd_data = rd_data_reg;
   assign rd_valid = rd_valid_reg;

   // ****************************************
   // pin cells
   // ****************************************
   localparam [`QBIO_WIDTH-1:0] LATCH_INIT_ALL = `QBIO_LATCH_RESET;

   genvar i;
   generate
      for (i = 0; i < `QBIO_WIDTH; i = i + 1) begin : g_bit
         qbio_bit #(
            .LATCH_INIT(LATCH_INIT_ALL[i])
         ) u_bit (
            .clk_sys(clk_sys),
            .sys_rst(port_rst),
            .latch_load(load),
            .latch_d(new_val[i]),
            .pin_in(pin_in[i]),
            .latch_q(latch_state[i]),
            .pin_sync(pin_sync[i]),
            .pin_out(pin_out[i]),
            .pin_oe(pin_oe[i])
         );
      end
   endgenerate
endmodule

// >>> testbench/qbio_port_assertions.sv
`timescale 1ns/1ps
// ****
// port checks
// ****
module qbio_chk (
   input wire clk_sys,
   input wire sys_rst,
   input wire master_clear_n,
   input wire [2:0] file_op,
   input wire [4:0] file_addr,
   input wire [2:0] bit_sel,
   input wire [7:0] wr_data,
   input wire op_valid,
   input wire op_ready,
   input wire [7:0] rd_data,
   input wire rd_valid,
   input wire [7:0] latch_state,
   input wire [7:0] pin_out,
   input wire [7:0] pin_oe
);
   wire acc = op_valid && op_ready && file_addr == 5'h07;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   a_oe_follows_latch: assert property (pin_oe == ~latch_state && pin_out == 8'h00)
      else $error("oe off");
   a_latch_hold: assert property (!acc |=> $stable(latch_state) || latch_state == 8'hff)
      else $error("latch moved");
   a_answer_pulse: assert property (acc |=> rd_valid)
      else $error("no answer");
   a_answer_quiet: assert property (!acc |=> !rd_valid)
      else $error("stray answer");
   a_write_load: assert property (acc && file_op == 3'h1 |=> latch_state == $past(wr_data))
      else $error("write lost");
   a_set_rewrite: assert property (acc && file_op == 3'h3 |=>
      latch_state == (rd_data | 8'h01 << $past(bit_sel))) else $error("set lost");
   a_clear_rewrite: assert property (acc && file_op == 3'h4 |=>
      latch_state == (rd_data & ~(8'h01 << $past(bit_sel)))) else $error("clear lost");
   a_rmw_rewrite: assert property (acc && file_op == 3'h5 |=> latch_state == rd_data)
      else $error("rewrite lost");
   a_clear_forces_high: assert property (!master_clear_n [*3] |->
      latch_state == 8'hff && !op_ready) else $error("master clear");
   c_set: cover property (acc && file_op == 3'h3);
   c_clear: cover property (acc && file_op == 3'h4);
   c_rmw: cover property (acc && file_op == 3'h5);
   c_master_clear: cover property (!master_clear_n [*3]);
endmodule
bind qbio_port qbio_chk u_chk (.clk_sys, .sys_rst, .master_clear_n, .file_op, .file_addr,
   .bit_sel, .wr_data, .op_valid, .op_ready, .rd_data, .rd_valid, .latch_state, .pin_out,
   .pin_oe);

// >>> testbench/qbio_ext.sv
`timescale 1ns/1ps
// ****
// open-collector far side
// ****
module qbio_ext (
   input wire [7:0] ext_low,
   input wire [7:0] pin_oe,
   output wire [7:0] pin_in
);
   // pull-up wins unless the port or the device sinks the line
   assign pin_in = ~(pin_oe | ext_low);
endmodule

// >>> testbench/test_qbio_port.sv
`timescale 1ns/1ps
// ****
// bench
// ****
module test_qbio_port;
   reg clk_sys = 0, sys_rst = 1, master_clear_n = 1, op_valid = 0;
   reg [2:0] file_op = 0, bit_sel = 0;
   reg [4:0] file_addr = 0;
   reg [7:0] wr_data = 0, ext_low = 0;
   wire op_ready, rd_valid;
   wire [7:0] rd_data, latch_state, pin_in, pin_out, pin_oe;
   integer n_fail = 0, check_count = 0;
   always #2.5 clk_sys = ~clk_sys;
   qbio_port u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .master_clear_n(master_clear_n),
      .file_op(file_op), .file_addr(file_addr), .bit_sel(bit_sel), .wr_data(wr_data),
      .op_valid(op_valid), .op_ready(op_ready), .rd_data(rd_data), .rd_valid(rd_valid),
      .latch_state(latch_state), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
   qbio_ext u_ext (.ext_low(ext_low), .pin_oe(pin_oe), .pin_in(pin_in));
   task chk(input [7:0] seen, input [7:0] exp);
      begin
         check_count = check_count + 1;
         if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("unexpected at %0t: %h vs %h", $time, seen, exp);
         end
      end
   endtask
   // spare cycles let the pin synchronisers settle before the next op
   task op(input [2:0] o, input [4:0] a, input [2:0] b, input [7:0] d);
      begin
         @(negedge clk_sys);
         {file_op, file_addr, bit_sel, wr_data, op_valid} = {o, a, b, d, 1'b1};
         @(negedge clk_sys);
         op_valid = 0;
         chk({7'h00, rd_valid}, {7'h00, a == 5'h07});
         repeat (3) @(negedge clk_sys);
      end
   endtask
   task t_reset;
      begin
         chk(latch_state, 8'hff);
         chk(pin_oe, 8'h00);
         chk({7'h00, op_ready}, 8'h01);
         $display("reset test done");
      end
   endtask
   task t_io;
      begin
         op(3'h1, 5'h07, 0, 8'h0f);
         chk(latch_state, 8'h0f);
         ext_low = 8'h01;
         repeat (2) @(negedge clk_sys);
         op(3'h3, 5'h07, 5, 0);
         chk(rd_data, 8'h0e);
         chk(latch_state, 8'h2e);
         op(3'h4, 5'h07, 1, 0);
         chk(latch_state, 8'h2c);
         chk(pin_oe, 8'hd3);
         chk(pin_out, 8'h00);
         op(3'h1, 5'h06, 0, 8'h55);
         chk(latch_state, 8'h2c);
         ext_low = 0;
         op(3'h2, 5'h07, 0, 0);
         chk(rd_data, 8'h2c);
         $display("io test done");
      end
   endtask
   task t_rmw;
      begin
         op(3'h1, 5'h07, 0, 8'hff);
         ext_low = 8'h81;
         repeat (2) @(negedge clk_sys);
         op(3'h5, 5'h07, 0, 0);
         chk(rd_data, 8'h7e);
         chk(latch_state, 8'h7e);
         ext_low = 8'h00;
         op(3'h2, 5'h07, 0, 0);
         chk(rd_data, 8'h7e);
         op(3'h0, 5'h07, 0, 8'h00);
         chk(latch_state, 8'h7e);
         $display("rmw test done");
      end
   endtask
   task t_master_clear;
      begin
         master_clear_n = 0;
         repeat (4) @(negedge clk_sys);
         chk(latch_state, 8'hff);
         chk(pin_oe, 8'h00);
         chk({7'h00, op_ready}, 8'h00);
         master_clear_n = 1;
         repeat (4) @(negedge clk_sys);
         chk({7'h00, op_ready}, 8'h01);
         op(3'h4, 5'h07, 3, 0);
         chk(latch_state, 8'hf7);
         $display("clear test done");
      end
   endtask
   task end_of_test;
      begin
         $display("checks %0d fails %0d", check_count, n_fail);
         if (n_fail == 0 && check_count > 0) $display("Test passed");
         else $display("Test failed");
         $finish;
      end
   endtask
   initial begin
      #2000;
      n_fail = n_fail + 1;
      end_of_test;
   end
   initial begin
      repeat (16) @(negedge clk_sys);
      sys_rst = 0;
      repeat (3) @(negedge clk_sys);
      t_reset;
      t_io;
      t_rmw;
      t_master_clear;
      end_of_test;
   end
endmodule
